// ===== rtl/clm_top.v
// How it works
// - Code 1,0,0 with cell bit 0: combinatorial output, eight terms, edge cells no feedback.
// - Code 1,0 with cell bit 1: buffer off, feedback from adjacent pin, edge cells no feedback.
// - Code 1,1 with cell bit 1: seven terms to OR, eighth enables, pin fed back.
// - Code 0,1 with cell bit 1: seven terms, eighth enables, own pin fed back.
// - Sum passes XOR with polarity bit; 0 active high, 1 active low, reversed at registered outputs.
// - Flip-flops reset low, so registered outputs show high after reset.
// - Combinatorial outputs follow their logic right after reset, no forced level.
// - Registers can be preloaded with any state from the output pins.
// - Secured device reads array and configuration back as zero.
// - Security bit clears only with the full erase of the array.
// - A 64-bit user signature of any content is held.
// - Signature reads back whatever the security bit holds.
// - Registered mode: capture on clock pin rise, feedback inverted, buffer by enable pin.
// - With registers allowed, clock and enable pins are kept out of the array.
// - Edge cells steer feedback by the inverted first global bit.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "clm_map.vh"

module clm_top (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [5:0] in_pin,
   input wire clk_pin,
   input wire oe_n_pin,
   input wire [7:0] io_in,
   output reg [7:0] io_out,
   output reg [7:0] io_oe
);

   // ****************************************************
   // Storage
   // ****************************************************
   reg [31:0] cfg_reg;
   reg [`CLM_TERM_IDX_W-1:0] term_idx_reg;
   reg [`CLM_TERM_W-1:0] fuse_reg [0:`CLM_TERM_COUNT-1];
   reg [63:0] sig_reg;
   reg secure_reg;
   reg preload_reg;
   reg erase_reg;
   reg [`CLM_PIN_COUNT-1:0] sync1_reg;
   reg [`CLM_PIN_COUNT-1:0] sync2_reg;
   reg [`CLM_PIN_COUNT-1:0] sync3_reg;
   reg [`CLM_PIN_COUNT-1:0] pin_reg;
   reg clk_pin_prev_reg;
   reg [31:0] rdata_next;
   reg rerr_next;
   integer k;

   wire regs_disallowed;
   wire emul_select;
   wire [7:0] cell_cfg;
   wire [7:0] pol_invert;
   wire [7:0] io_lvl;
   wire [5:0] in_lvl;
   wire clk_lvl;
   wire oe_n_lvl;
   wire clk_edge;
   wire [`CLM_ARRAY_INPUTS-1:0] arr_in;
   wire [`CLM_TERM_W-1:0] literals;
   wire [`CLM_TERM_COUNT-1:0] term_val;
   wire [7:0] cell_out;
   wire [7:0] cell_en;
   wire [7:0] cell_fb;
   wire [7:0] cell_q;
   wire wr_go;
   wire rd_go;
   wire [`CLM_PIN_COUNT-1:0] pins_raw;
   wire [`CLM_PIN_COUNT-1:0] pin_stable;

   assign regs_disallowed = cfg_reg[`CLM_CFG_SG0_BIT];
   assign emul_select = cfg_reg[`CLM_CFG_SG1_BIT];
   assign cell_cfg = cfg_reg[`CLM_CFG_CELL_LSB+7:`CLM_CFG_CELL_LSB];
   assign pol_invert = cfg_reg[`CLM_CFG_POL_LSB+7:`CLM_CFG_POL_LSB];

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   assign pins_raw = {io_in, oe_n_pin, clk_pin, in_pin};
   assign pin_stable = ~(sync2_reg ^ sync3_reg);

   // Three stages; level taken once stages two and three agree
   always @(posedge clk) begin
      if (!rst_n) begin
         sync1_reg <= 16'h0000;
         sync2_reg <= 16'h0000;
         sync3_reg <= 16'h0000;
         pin_reg <= 16'h0000;
         clk_pin_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg <= (sync3_reg & pin_stable) | (pin_reg & ~pin_stable);
         clk_pin_prev_reg <= pin_reg[6];
      end
   end

   assign in_lvl = pin_reg[5:0];
   assign clk_lvl = pin_reg[6];
   assign oe_n_lvl = pin_reg[7];
   assign io_lvl = pin_reg[15:8];
   assign clk_edge = clk_lvl & ~clk_pin_prev_reg;

   // ****************************************************
   // AND array
   // ****************************************************
   // Clock and enable pins drop out once registers are allowed
   assign arr_in = {cell_fb, oe_n_lvl & regs_disallowed, clk_lvl & regs_disallowed,
                    in_lvl};

   genvar gi;
   generate
      for (gi = 0; gi < `CLM_ARRAY_INPUTS; gi = gi + 1) begin : g_lit
         // Even bit true form, odd bit complement
         assign literals[2*gi] = arr_in[gi];
         assign literals[2*gi+1] = ~arr_in[gi];
      end
      for (gi = 0; gi < `CLM_TERM_COUNT; gi = gi + 1) begin : g_term
         // Unconnected fuses pass; true plus complement forces low
         assign term_val[gi] = &(~fuse_reg[gi] | literals);
      end
   endgenerate

   // ****************************************************
   // Macrocells
   // ****************************************************
   generate
      for (gi = 0; gi < `CLM_CELLS; gi = gi + 1) begin : g_cell
         clm_macrocell #(
            .IS_EDGE((gi == 0) || (gi == `CLM_CELLS - 1))
         ) u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .terms(term_val[8*gi+7:8*gi]),
            .regs_disallowed(regs_disallowed),
            .emul_select(emul_select),
            .cell_cfg(cell_cfg[gi]),
            .pol_invert(pol_invert[gi]),
            .clk_edge(clk_edge),
            .oe_active(~oe_n_lvl),
            .own_pin(io_lvl[gi]),
            .adj_pin(io_lvl[(gi < 4) ? gi + 1 : gi - 1]),
            .preload(preload_reg),
            .preload_val(io_lvl[gi]),
            .out_val(cell_out[gi]),
            .out_en(cell_en[gi]),
            .feedback(cell_fb[gi]),
            .q_state(cell_q[gi])
         );
      end
   endgenerate

   // Pin drivers, buffer off for unsupported codes
   always @(posedge clk) begin
      if (!rst_n) begin
         io_out <= 8'h00;
         io_oe <= 8'h00;
      end else begin
         io_out <= cell_out;
         io_oe <= cell_en;
      end
   end

   // ****************************************************
   // APB slave
   // ****************************************************
   // Writes commit at the edge where pready is seen high, reads at the edge before
   assign wr_go = psel & penable & pready & pwrite;
   assign rd_go = psel & penable & ~pready & ~pwrite;

   // Read mux; array and configuration hidden when secured
   always @* begin
      rdata_next = 32'h00000000;
      rerr_next = 1'b0;
      case (paddr)
         `CLM_ADDR_CFG: begin
            rdata_next = secure_reg ? 32'h00000000 : cfg_reg;
         end
         `CLM_ADDR_TERM_IDX: begin
            rdata_next = {26'h0000000, term_idx_reg};
         end
         `CLM_ADDR_TERM_DATA: begin
            rdata_next = secure_reg ? 32'h00000000 : fuse_reg[term_idx_reg];
         end
         `CLM_ADDR_SIG_LO: begin
            rdata_next = sig_reg[31:0];
         end
         `CLM_ADDR_SIG_HI: begin
            rdata_next = sig_reg[63:32];
         end
         `CLM_ADDR_CTRL: begin
            rdata_next = 32'h00000000;
         end
         `CLM_ADDR_STATUS: begin
            rdata_next[`CLM_STAT_SECURE_BIT] = secure_reg;
            rdata_next[`CLM_STAT_REGDEV_BIT] = ~regs_disallowed;
            rdata_next[`CLM_STAT_Q_LSB+7:`CLM_STAT_Q_LSB] = cell_q;
            rdata_next[`CLM_STAT_OUT_LSB+7:`CLM_STAT_OUT_LSB] = io_out;
            rdata_next[`CLM_STAT_OE_LSB+7:`CLM_STAT_OE_LSB] = io_oe;
         end
         default: begin
            rerr_next = 1'b1;
         end
      endcase
   end

   // Handshake: one wait state, then pready for one cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= rerr_next;
            prdata <= rd_go ? rdata_next : 32'h00000000;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // ****************************************************
   // Programming registers
   // ****************************************************
   // Erase runs one cycle after its write and wipes all but the term index
   always @(posedge clk) begin
      if (!rst_n) begin
         cfg_reg <= `CLM_CFG_RESET;
         term_idx_reg <= 6'h00;
         sig_reg <= `CLM_SIG_RESET;
         secure_reg <= 1'b0;
         preload_reg <= 1'b0;
         erase_reg <= 1'b0;
         for (k = 0; k < `CLM_TERM_COUNT; k = k + 1) begin
            fuse_reg[k] <= 32'h00000000;
         end
      end else begin
         preload_reg <= 1'b0;
         erase_reg <= 1'b0;
         if (erase_reg) begin
            cfg_reg <= `CLM_CFG_RESET;
            sig_reg <= `CLM_SIG_RESET;
            secure_reg <= 1'b0;
            for (k = 0; k < `CLM_TERM_COUNT; k = k + 1) begin
               fuse_reg[k] <= 32'h00000000;
            end
         end else if (wr_go) begin
            case (paddr)
               `CLM_ADDR_CFG: begin
                  cfg_reg <= pwdata;
               end
               `CLM_ADDR_TERM_IDX: begin
                  term_idx_reg <= pwdata[`CLM_TERM_IDX_W-1:0];
               end
               `CLM_ADDR_TERM_DATA: begin
                  fuse_reg[term_idx_reg] <= pwdata;
               end
               `CLM_ADDR_SIG_LO: begin
                  sig_reg[31:0] <= pwdata;
               end
               `CLM_ADDR_SIG_HI: begin
                  sig_reg[63:32] <= pwdata;
               end
               `CLM_ADDR_CTRL: begin
                  erase_reg <= pwdata[`CLM_CTRL_ERASE_BIT];
                  preload_reg <= pwdata[`CLM_CTRL_PRELOAD_BIT];
                  if (pwdata[`CLM_CTRL_SECURE_BIT]) begin
                     secure_reg <= 1'b1;
                  end
               end
               default: begin
                  term_idx_reg <= term_idx_reg;
               end
            endcase
         end
      end
   end

endmodule // clm_top

// ===== rtl/clm_map.vh
`ifndef CLM_MAP_VH
`define CLM_MAP_VH

// ****************************************************
// Register byte offsets
// ****************************************************
`define CLM_ADDR_CFG 8'h00
`define CLM_ADDR_TERM_IDX 8'h04
`define CLM_ADDR_TERM_DATA 8'h08
`define CLM_ADDR_SIG_LO 8'h0C
`define CLM_ADDR_SIG_HI 8'h10
`define CLM_ADDR_CTRL 8'h14
`define CLM_ADDR_STATUS 8'h18

// ****************************************************
// Configuration word fields
// ****************************************************
`define CLM_CFG_SG0_BIT 0
`define CLM_CFG_SG1_BIT 1
`define CLM_CFG_CELL_LSB 8
`define CLM_CFG_POL_LSB 16
`define CLM_CFG_RESET 32'h00000000

// ****************************************************
// Control and status fields
// ****************************************************
`define CLM_CTRL_ERASE_BIT 0
`define CLM_CTRL_SECURE_BIT 1
`define CLM_CTRL_PRELOAD_BIT 2
`define CLM_STAT_SECURE_BIT 0
`define CLM_STAT_REGDEV_BIT 1
`define CLM_STAT_Q_LSB 8
`define CLM_STAT_OUT_LSB 16
`define CLM_STAT_OE_LSB 24

// ****************************************************
// Array geometry
// ****************************************************
`define CLM_CELLS 8
`define CLM_TERMS_PER_CELL 8
`define CLM_TERM_COUNT 64
`define CLM_TERM_IDX_W 6
`define CLM_ARRAY_INPUTS 16
`define CLM_TERM_W 32
`define CLM_IN_PINS 6
`define CLM_PIN_COUNT 16
`define CLM_SIG_RESET 64'h0000000000000000

`endif

// ===== rtl/clm_macrocell.v
`timescale 1ns/1ns
`include "clm_map.vh"

module clm_macrocell #(
   parameter IS_EDGE = 0
) (
   input wire clk,
   input wire rst_n,
   input wire [7:0] terms,
   input wire regs_disallowed,
   input wire emul_select,
   input wire cell_cfg,
   input wire pol_invert,
   input wire clk_edge,
   input wire oe_active,
   input wire own_pin,
   input wire adj_pin,
   input wire preload,
   input wire preload_val,
   output reg out_val,
   output reg out_en,
   output reg feedback,
   output wire q_state
);

   reg q_reg;
   reg q_next;
   reg sum8;
   reg sum7;
   reg fb_sel;
   wire mode_reg;
   wire mode_cout;
   wire mode_din;
   wire mode_cio_nr;
   wire mode_cio_r;

   assign q_state = q_reg;

   // ****************************************************
   // Mode decode
   // ****************************************************
   assign mode_reg = ~regs_disallowed & emul_select & ~cell_cfg;
   assign mode_cout = regs_disallowed & ~emul_select & ~cell_cfg;
   assign mode_din = regs_disallowed & ~emul_select & cell_cfg;
   assign mode_cio_nr = regs_disallowed & emul_select & cell_cfg;
   assign mode_cio_r = ~regs_disallowed & emul_select & cell_cfg;

   // Sums, output select, enable select and feedback select
   always @* begin
      sum8 = (|terms) ^ pol_invert;
      sum7 = (|terms[6:0]) ^ pol_invert;
      fb_sel = IS_EDGE ? ~regs_disallowed : emul_select;
      out_val = 1'b0;
      out_en = 1'b0;
      feedback = 1'b0;
      q_next = q_reg;
      if (mode_reg) begin
         q_next = clk_edge ? sum8 : q_reg;
         out_val = ~q_reg;
         out_en = oe_active;
      end else if (mode_cout) begin
         out_val = sum8;
         out_en = 1'b1;
      end else if (mode_cio_nr || mode_cio_r) begin
         out_val = sum7;
         out_en = terms[7];
      end
      // Unsupported code leaves the buffer off
      if (fb_sel) begin
         feedback = cell_cfg ? own_pin : ~q_reg;
      end else if (IS_EDGE == 0) begin
         feedback = (mode_din || cell_cfg) ? adj_pin : own_pin;
      end
      if (mode_cio_nr) begin
         feedback = own_pin;
      end
      if (preload) begin
         q_next = ~preload_val;
      end
   end

   // Cell flip-flop, cleared at reset
   always @(posedge clk) begin
      if (!rst_n) begin
         q_reg <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end

endmodule // clm_macrocell

// ===== verification/clm_top_sva.sv
`timescale 1ns/1ns
`include "clm_map.vh"
// ********
// Bus and pin checks
// ********
module clm_top_chk (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [7:0] io_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Handshake timing
   property p_ready_wait;
      psel && penable && !pready |=> pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_ready_cause;
      pready |-> $past(psel) && $past(penable);
   endproperty
   // Error response
   property p_err_pair;
      pslverr |-> pready;
   endproperty
   property p_err_data;
      pready && pslverr && !pwrite |-> prdata == 32'h00000000;
   endproperty
   property p_ctrl_zero;
      pready && !pwrite && paddr == `CLM_ADDR_CTRL |-> prdata == 32'h00000000 && !pslverr;
   endproperty
   property p_unmapped;
      pready && paddr > `CLM_ADDR_STATUS |-> pslverr;
   endproperty
   property p_mapped;
      pready && paddr <= `CLM_ADDR_STATUS && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   // Buffers off after reset, config code unsupported
   property p_rst_quiet;
      $rose(rst_n) |-> io_oe == 8'h00 && !pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready late");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
   a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
   a_err_data: assert property (p_err_data) else $error("error read not zero");
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("control read not zero");
   a_unmapped: assert property (p_unmapped) else $error("unmapped without error");
   a_mapped: assert property (p_mapped) else $error("mapped with error");
   a_rst_quiet: assert property (p_rst_quiet) else $error("buffers on after reset");
   c_write: cover property (pready && pwrite);
   c_read: cover property (pready && !pwrite);
   c_err: cover property (pslverr);
endmodule // clm_top_chk

bind clm_top clm_top_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .io_oe(io_oe));

// ===== verification/clm_board.sv
`timescale 1ns/1ns
// ********
// Board logic on the I/O pins
// ********
module clm_board (
   input wire [7:0] io_out,
   input wire [7:0] io_oe,
   input wire [7:0] ext_val,
   input wire [7:0] ext_drv,
   output wire [7:0] io_in
);
   // Wire level: cell, board driver, else pull-up
   assign io_in = (io_oe & io_out) | (~io_oe & ext_drv & ext_val) | (~io_oe & ~ext_drv);
endmodule // clm_board

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`include "clm_map.vh"
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [5:0] in_pin = 6'h00;
   logic clk_pin = 1'b0;
   logic oe_n_pin = 1'b0;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ext_drv = 8'h00;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [7:0] io_in;
   wire [7:0] io_out;
   wire [7:0] io_oe;
   integer error_cnt = 0;
   integer checks = 0;
   integer seed = 46940;
   integer cyc = 0;
   integer m;
   integer k;
   logic [31:0] rd;
   logic er;
   logic [7:0] pol;
   logic [7:0] s;
   logic [7:0] e;
   logic [31:0] lo;
   logic [15:0] mcfg [5] = '{16'h0001, 16'hFF01, 16'hFF03, 16'hFF02, 16'h0000};

   always #25 clk = ~clk;

   clm_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_pin(in_pin), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe));
   clm_board u_board (.io_out(io_out), .io_oe(io_oe), .ext_val(ext_val), .ext_drv(ext_drv),
      .io_in(io_in));

   // ********
   // Tasks and expectations
   // ********
   task wrap_up;
      begin
         $display("error_cnt %0d checks %0d", error_cnt, checks);
         if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task cmp32(input logic [31:0] g, input logic [31:0] x);
      checks = checks + 1;
      if (g !== x) begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task cmp8(input logic [7:0] g, input logic [7:0] x);
      cmp32({24'h000000, g}, {24'h000000, x});
   endtask
   // One transfer; result left in rd and er
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge clk);
         n = n + 1;
      end
      if (n == 16) begin
         error_cnt = error_cnt + 1;
         wrap_up;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Term 0 on input 0 (cell 1 empty), term 7 on input 1, rest forced low
   function logic [31:0] fuse(input integer i);
      if (i % 8 == 7)
         return 32'h00000004;
      if (i % 8 != 0)
         return 32'h00000003;
      return (i == 8) ? 32'h00000000 : 32'h00000001;
   endfunction
   function logic [7:0] t0v(input logic [5:0] ip);
      return {{6{ip[0]}}, 1'b1, ip[0]};
   endfunction

   // Cycle ceiling
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 8000) begin
         error_cnt = error_cnt + 1;
         wrap_up;
      end
   end

   // ********
   // Main sequence
   // ********
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, `CLM_ADDR_CFG, 32'h0);
      cmp32(rd, `CLM_CFG_RESET);
      apb(0, `CLM_ADDR_SIG_HI, 32'h0);
      cmp32(rd, 32'h00000000);
      cmp8(io_oe, 8'h00);
      apb(0, 8'h1C, 32'h0);
      cmp32({rd[30:0], er}, 32'h00000001);
      apb(1, `CLM_ADDR_CTRL, 32'h00000001);
      for (k = 0; k < 64; k++) begin
         apb(1, `CLM_ADDR_TERM_IDX, 32'(k));
         apb(1, `CLM_ADDR_TERM_DATA, fuse(k));
      end
      apb(0, `CLM_ADDR_TERM_DATA, 32'h0);
      cmp32(rd, fuse(63));
      // Combinatorial modes and the unsupported code with random inputs and polarity
      for (m = 0; m < 5; m++) begin
         for (k = 0; k < 6; k++) begin
            in_pin <= $random(seed);
            pol = $random(seed);
            apb(1, `CLM_ADDR_CFG, {8'h00, pol, mcfg[m]});
            repeat (6) @(posedge clk);
            s = t0v(in_pin) | ((m == 0) ? {8{in_pin[1]}} : 8'h00);
            e = (m == 0) ? 8'hFF : (m == 2 || m == 3) ? {8{in_pin[1]}} : 8'h00;
            cmp8(io_oe, e);
            cmp8(io_out & e, (s ^ pol) & e);
         end
      end
      // Registered mode, clock pin, enable pin, preload
      pol = $random(seed);
      in_pin <= $random(seed);
      apb(1, `CLM_ADDR_CFG, {8'h00, pol, 16'h0002});
      repeat (6) @(posedge clk);
      cmp8(io_out, 8'hFF);
      cmp8(io_oe, 8'hFF);
      s = t0v(in_pin) | {8{in_pin[1]}};
      clk_pin <= 1'b1;
      repeat (8) @(posedge clk);
      clk_pin <= 1'b0;
      cmp8(io_out, ~(s ^ pol));
      oe_n_pin <= 1'b1;
      repeat (6) @(posedge clk);
      cmp8(io_oe, 8'h00);
      e = $random(seed);
      ext_val <= e;
      ext_drv <= 8'hFF;
      repeat (6) @(posedge clk);
      apb(1, `CLM_ADDR_CTRL, 32'h00000004);
      ext_drv <= 8'h00;
      oe_n_pin <= 1'b0;
      repeat (6) @(posedge clk);
      cmp8(io_out, e);
      apb(0, `CLM_ADDR_STATUS, 32'h0);
      cmp8(rd[15:8], ~e);
      // Signature, security and erase
      lo = $random(seed);
      apb(1, `CLM_ADDR_SIG_LO, lo);
      apb(1, `CLM_ADDR_CTRL, 32'h00000002);
      apb(1, `CLM_ADDR_CTRL, 32'h00000000);
      apb(0, `CLM_ADDR_STATUS, 32'h0);
      cmp32({31'h0, rd[0]}, 32'h00000001);
      apb(0, `CLM_ADDR_CFG, 32'h0);
      cmp32(rd, 32'h00000000);
      apb(0, `CLM_ADDR_TERM_DATA, 32'h0);
      cmp32(rd, 32'h00000000);
      apb(0, `CLM_ADDR_SIG_LO, 32'h0);
      cmp32(rd, lo);
      apb(1, `CLM_ADDR_CTRL, 32'h00000001);
      apb(0, `CLM_ADDR_STATUS, 32'h0);
      cmp32({31'h0, rd[0]}, 32'h00000000);
      apb(0, `CLM_ADDR_SIG_LO, 32'h0);
      cmp32(rd, `CLM_SIG_RESET);
      wrap_up;
   end
endmodule // tb_top
